// *** rtl/scm_clock_ctrl.sv ***
// scm_clock_ctrl: system clock select, divider and power mode control
// assumes fast_rc_osc and slow_rc_osc arrive as pins; wakeup from outside
`timescale 1ns/1ps
module scm_clock_ctrl
   import scm_pkg::*;
(
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_fast_rc_osc,
   input  wire logic                i_slow_rc_osc,
   input  wire logic                i_halt,
   input  wire logic                i_wakeup,
   input  wire logic                i_wdt_enable,
   input  wire logic [7:0]          i_addr,
   input  wire logic [7:0]          i_wdata,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   output logic      [7:0]          o_rdata,
   output logic                     o_system_clock_en,
   output logic      [2:0]          o_sys_clk_select,
   output scm_pkg::scm_mode_t       o_mode,
   output scm_pkg::scm_gate_t       o_gate,
   output logic                     o_fast_osc_stable_flag
);
   import scm_pkg::*;

   typedef struct packed {
      logic [1:0] f_sync;
      logic       f_prev;
      logic [1:0] s_sync;
      logic       s_prev;
      logic [2:0] sel;
      logic [2:0] sel_act;
      logic       switching;
      logic       fast_osc_idle_enable;
      logic       slow_osc_idle_enable;
      logic       fosc_en;
      logic       stable;
      logic [7:0] stab_cnt;
      logic [5:0] div;
      logic       halted;
      scm_mode_t  mode;
      logic       sys_en;
      logic [7:0] rdata;
   } scm_state_t;

   scm_state_t st;
   scm_state_t next_st;

   // tick of the selected source for a given select code
   function automatic logic src_tick(input logic [2:0] s,
                                     input logic [5:0] d,
                                     input logic ft,
                                     input logic stk);
      logic [5:0] m;
      m = 6'((7'h01 << s) - 7'h01);
      if (s == SEL_SUB)
         src_tick = stk;
      else
         src_tick = ft && ((d & m) == m);
   endfunction : src_tick

   logic fast_tick;
   logic slow_tick;
   logic fast_need;
   logic sub_need;

   always_comb begin
      next_st = st;
      next_st.f_sync = {st.f_sync[0], i_fast_rc_osc};
      next_st.s_sync = {st.s_sync[0], i_slow_rc_osc};
      next_st.f_prev = st.f_sync[1];
      next_st.s_prev = st.s_sync[1];
      fast_tick = st.f_sync[1] && !st.f_prev && st.fosc_en;
      slow_tick = st.s_sync[1] && !st.s_prev && o_gate.sub_on;
      next_st.rdata = 8'h00;

      // register port
      if (i_wr) begin
         if (i_addr == REG_SYS_CLK_CTRL) begin
            next_st.sel                  = i_wdata[SEL_LSB +: 3];
            next_st.fast_osc_idle_enable = i_wdata[FAST_IDLE_BIT];
            next_st.slow_osc_idle_enable = i_wdata[SLOW_IDLE_BIT];
         end else if (i_addr == REG_FOSC) begin
            if (i_wdata[ENABLE_BIT] && !st.fosc_en) begin
               next_st.stable   = 1'b0;
               next_st.stab_cnt = 8'h00;
            end
            next_st.fosc_en = i_wdata[ENABLE_BIT];
         end
      end
      if (i_rd) begin
         if (i_addr == REG_SYS_CLK_CTRL)
            next_st.rdata = {st.sel, 3'h0, st.fast_osc_idle_enable,
                             st.slow_osc_idle_enable};
         else if (i_addr == REG_FOSC)
            next_st.rdata = {6'h00, st.stable, st.fosc_en};
         else if (i_addr == REG_MODE)
            next_st.rdata = {5'h00, st.mode};
         else
            next_st.rdata = 8'h00;
      end

      // fast osc settle counter
      if (!st.fosc_en)
         next_st.stable = 1'b0;
      else if (!st.stable && fast_tick) begin
         if (st.stab_cnt == STABLE_CNT - 8'h01)
            next_st.stable = 1'b1;
         else
            next_st.stab_cnt = st.stab_cnt + 8'h01;
      end

      if (fast_tick)
         next_st.div = st.div + 6'h01;

      // glitch-free switch: hold old source until its period ends,
      // then take the new select the next cycle, ticking on the shared divider phase
      next_st.sys_en = 1'b0;
      if (st.sel != st.sel_act && !st.switching) begin
         if (src_tick(st.sel_act, st.div, fast_tick, slow_tick))
            next_st.switching = 1'b1;
      end else if (st.switching) begin
         next_st.sel_act = st.sel;
         next_st.switching = 1'b0;
      end else
         next_st.sys_en = src_tick(st.sel_act, st.div,
                                   fast_tick, slow_tick);

      // mode machine
      if (i_halt && !st.halted) begin
         next_st.halted = 1'b1;
         case ({st.fast_osc_idle_enable, st.slow_osc_idle_enable})
            2'b00:   next_st.mode = SCM_SLEEP;
            2'b01:   next_st.mode = SCM_STANDBY_SLOW_ONLY;
            2'b11:   next_st.mode = SCM_STANDBY_BOTH_CLOCKS;
            default: next_st.mode = SCM_STANDBY_FAST_ONLY;
         endcase
      end else if (st.halted && i_wakeup)
         next_st.halted = 1'b0;
      // follow the select taking effect now, so mode never lags the select
      if (!next_st.halted)
         next_st.mode = (next_st.sel_act == SEL_SUB) ? SCM_SLOW
                                                     : SCM_FAST;
      // no tick from the halt edge onward, the cpu is already off
      if (next_st.halted)
         next_st.sys_en = 1'b0;
   end

   // gating per mode
   always_comb begin
      fast_need = 1'b1;
      sub_need  = 1'b1;
      o_gate    = '0;
      case (st.mode)
         SCM_FAST:  begin
            fast_need = 1'b1;
            sub_need  = 1'b1;
         end
         SCM_SLOW:  begin
            fast_need = st.fosc_en;
            sub_need  = 1'b1;
         end
         SCM_STANDBY_SLOW_ONLY: begin
            fast_need = 1'b0;
            sub_need  = 1'b1;
         end
         SCM_STANDBY_BOTH_CLOCKS: begin
            fast_need = 1'b1;
            sub_need  = 1'b1;
         end
         SCM_STANDBY_FAST_ONLY: begin
            fast_need = 1'b1;
            sub_need  = 1'b0;
         end
         default:   begin
            fast_need = 1'b0;
            sub_need  = 1'b0;
         end
      endcase
      // a disabled fast osc stays off whatever the mode asks for
      o_gate.fast_on    = fast_need && st.fosc_en;
      o_gate.sub_on     = sub_need;
      o_gate.slow_rc_on = (st.mode == SCM_SLEEP) ? i_wdt_enable
                                                 : 1'b1;
      o_gate.cpu_on     = !st.halted;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st         <= '0;
         st.sel     <= SEL_RST;
         st.sel_act <= SEL_RST;
         st.fosc_en <= FOSC_EN_RST;
         st.mode    <= SCM_FAST;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata                = st.rdata;
   assign o_system_clock_en      = st.sys_en;
   assign o_sys_clk_select       = st.sel_act;
   assign o_mode                 = st.mode;
   assign o_fast_osc_stable_flag = st.stable;
endmodule : scm_clock_ctrl

// *** rtl/scm_pkg.sv ***
// scm_pkg: constants and types for the system clock and power mode block
// assumes a single 40 MHz register clock; oscillators arrive as pins
package scm_pkg;
   localparam int        FAST_OSC_HZ      = 8000000;
   localparam int        SLOW_OSC_HZ      = 32000;
   localparam logic [1:0] ADDR_W          = 2'h0;
   localparam logic [7:0] REG_SYS_CLK_CTRL = 8'h00;
   localparam logic [7:0] REG_FOSC        = 8'h01;
   localparam logic [7:0] REG_MODE        = 8'h02;
   localparam int        SEL_LSB          = 5;
   localparam int        FAST_IDLE_BIT    = 1;
   localparam int        SLOW_IDLE_BIT    = 0;
   localparam int        STABLE_BIT       = 1;
   localparam int        ENABLE_BIT       = 0;
   localparam logic [2:0] SEL_RST         = 3'h0;
   localparam logic [2:0] SEL_SUB         = 3'h7;
   localparam logic      FOSC_EN_RST      = 1'b1;
   // fast osc settle time, in fast oscillator cycles
   localparam int        STABLE_FCYC      = 64;
   localparam logic [7:0] STABLE_CNT      = 8'(STABLE_FCYC);

   typedef enum logic [2:0] {
      SCM_FAST                = 3'b000,
      SCM_SLOW                = 3'b001,
      SCM_STANDBY_SLOW_ONLY   = 3'b010,
      SCM_STANDBY_BOTH_CLOCKS = 3'b011,
      SCM_STANDBY_FAST_ONLY   = 3'b100,
      SCM_SLEEP               = 3'b101
   } scm_mode_t;

   typedef struct packed {
      logic fast_on;
      logic sub_on;
      logic slow_rc_on;
      logic cpu_on;
   } scm_gate_t;
endpackage : scm_pkg

// *** sim/scm_clock_ctrl_checker.sv ***
// scm_clock_ctrl_checker: port assertions for scm_clock_ctrl
// assumes one clock domain; bound onto the top module
`timescale 1ns/1ps
module scm_clock_ctrl_checker
   import scm_pkg::*;
(
   input wire logic           i_clk,
   input wire logic           i_rst_n,
   input wire logic           i_halt,
   input wire logic           i_wdt_enable,
   input wire logic           i_rd,
   input wire logic [7:0]     o_rdata,
   input wire logic           o_system_clock_en,
   input wire logic [2:0]     o_sys_clk_select,
   input wire scm_pkg::scm_mode_t o_mode,
   input wire scm_pkg::scm_gate_t o_gate
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire run = (o_mode == SCM_FAST) || (o_mode == SCM_SLOW);
   a_halt_cpu_off: assert property (i_halt && run |=> !o_gate.cpu_on)
      else $error("cpu left on after halt");
   a_run_cpu_on: assert property (run |-> o_gate.cpu_on)
      else $error("cpu off in run mode");
   a_halt_no_tick: assert property (!run |-> !o_system_clock_en)
      else $error("tick while halted");
   a_sleep_rc_wdt: assert property (o_mode == SCM_SLEEP |->
      o_gate.slow_rc_on == i_wdt_enable) else $error("slow rc in sleep");
   a_sleep_gates: assert property (o_mode == SCM_SLEEP |->
      !o_gate.fast_on && !o_gate.sub_on) else $error("sleep gating");
   a_slow_only_gates: assert property (
      o_mode == SCM_STANDBY_SLOW_ONLY |-> !o_gate.fast_on && o_gate.sub_on)
      else $error("slow-only standby gating");
   a_fast_only_gates: assert property (
      o_mode == SCM_STANDBY_FAST_ONLY |-> !o_gate.sub_on && o_gate.slow_rc_on)
      else $error("fast-only standby gating");
   a_switch_quiet: assert property (
      $changed(o_sys_clk_select) |->
      !o_system_clock_en && !$past(o_system_clock_en))
      else $error("tick beside source switch");
   a_slow_uses_sub: assert property (o_mode == SCM_SLOW |->
      o_sys_clk_select == SEL_SUB) else $error("slow mode select");
   a_tick_single: assert property (o_system_clock_en |=>
      !o_system_clock_en) else $error("tick wider than one cycle");
   a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside slot");
   cover property (o_mode == SCM_SLEEP);
   cover property (o_mode == SCM_SLOW);
   cover property (o_mode == SCM_STANDBY_BOTH_CLOCKS);
endmodule : scm_clock_ctrl_checker

bind scm_clock_ctrl scm_clock_ctrl_checker i_chk (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_halt(i_halt), .i_wdt_enable(i_wdt_enable),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_system_clock_en(o_system_clock_en),
   .o_sys_clk_select(o_sys_clk_select), .o_mode(o_mode), .o_gate(o_gate));

// *** sim/testbench.sv ***
// testbench: register-driven checks of clock select, dividers and halt
// assumes 40 MHz clock; oscillator pins made here from cycle counts
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module testbench;
   import scm_pkg::*;
   logic       clk = 0, rst_n = 0, fosc = 0, sosc = 0;
   logic       halt = 0, wake = 0, wdt = 1, wr = 0, rd = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic       tick, stable;
   logic [2:0] sel;
   scm_mode_t  mode;
   scm_gate_t  gate;
   int         errors = 0, samples_checked = 0, cyc = 0;
   scm_mode_t  hmode[4] = '{SCM_SLEEP, SCM_STANDBY_SLOW_ONLY,
                            SCM_STANDBY_FAST_ONLY, SCM_STANDBY_BOTH_CLOCKS};
   scm_gate_t  hgate[4] = '{4'h2, 4'h6, 4'hA, 4'hE};
   scm_clock_ctrl i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_fast_rc_osc(fosc),
      .i_slow_rc_osc(sosc), .i_halt(halt), .i_wakeup(wake),
      .i_wdt_enable(wdt), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .o_system_clock_en(tick),
      .o_sys_clk_select(sel), .o_mode(mode), .o_gate(gate),
      .o_fast_osc_stable_flag(stable));
   initial begin
      forever #12.5 clk = ~clk;
   end
   // fast osc 5 clocks a period, slow osc 1250
   always @(posedge clk) begin
      cyc <= cyc + 1;
      fosc <= (cyc % 5) < 2;
      sosc <= (cyc % 1250) < 625;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask : rd_reg
   task automatic strobe(input bit w);
      @(posedge clk);
      if (w) wake <= 1'b1;
      else halt <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      halt <= 1'b0;
      #1;
   endtask : strobe
   task automatic count_ticks(input int n, input int e);
      int c = 0;
      repeat (n) begin
         @(posedge clk);
         #1 if (tick === 1'b1) c++;
      end
      `CHK(c, e)
   endtask : count_ticks
   task automatic complete_run();
      $display("errors %0d checks %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      #(60000 * 25);
      errors++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(REG_SYS_CLK_CTRL, 8'h00);
      rd_reg(REG_FOSC, 8'h01);
      wr_reg(8'h05, 8'hFF);
      rd_reg(8'h05, 8'h00);
      rd_reg(REG_SYS_CLK_CTRL, 8'h00);
      repeat (400) @(posedge clk);
      #1 `CHK(stable, 1'b1)
      rd_reg(REG_FOSC, 8'h03);
      wr_reg(REG_FOSC, 8'h00);
      wr_reg(REG_FOSC, 8'h01);
      rd_reg(REG_FOSC, 8'h01);
      #1 `CHK(stable, 1'b0)
      repeat (400) @(posedge clk);
      rd_reg(REG_FOSC, 8'h03);
      // 640 clocks hold exactly 128 fast edges
      for (int s = 0; s < 7; s++) begin
         wr_reg(REG_SYS_CLK_CTRL, 8'(s << 5));
         repeat (400) @(posedge clk);
         #1 `CHK(sel, 3'(s))
         count_ticks(640, 128 >> s);
      end
      wr_reg(REG_SYS_CLK_CTRL, 8'hE0);
      repeat (2600) @(posedge clk);
      rd_reg(REG_MODE, 8'h01);
      count_ticks(2500, 2);
      `CHK(gate.fast_on, 1'b1)
      wr_reg(REG_FOSC, 8'h00);
      #1 `CHK(gate.fast_on, 1'b0)
      wr_reg(REG_FOSC, 8'h01);
      for (int b = 0; b < 4; b++) begin
         wr_reg(REG_SYS_CLK_CTRL, 8'hE0 | 8'(b));
         strobe(1'b0);
         `CHK(mode, hmode[b])
         `CHK(gate, hgate[b])
         if (b == 0) begin
            @(posedge clk);
            wdt <= 1'b0;
            #1 `CHK(gate, 4'h0)
         end
         strobe(1'b1);
         `CHK(mode, SCM_SLOW)
      end
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK(mode, SCM_FAST)
      `CHK(gate, 4'hF)
      `CHK(stable, 1'b0)
      @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(REG_SYS_CLK_CTRL, 8'h00);
      rd_reg(REG_FOSC, 8'h01);
      complete_run();
   end
endmodule : testbench
